// ### hw/sdb_cfg.svh
// Fixed figures for the SDRAM device-side bank and read timing model
`ifndef SDB_CFG_SVH
`define SDB_CFG_SVH
// ------------------------------------------------------------
// Geometry
// ------------------------------------------------------------
`define SDB_BANKS 4
`define SDB_BA_W 2
`define SDB_ROW_W 13
`define SDB_COL_W 10
`define SDB_DQ_W 16
`define SDB_MEM_WORDS 256
`define SDB_MEM_AW 8
`define SDB_FIFO_DEPTH 16
`define SDB_AP_BIT 10
// ------------------------------------------------------------
// Burst length and latency codes
// ------------------------------------------------------------
`define SDB_BL_1 3'h0
`define SDB_BL_2 3'h1
`define SDB_BL_4 3'h2
`define SDB_BL_8 3'h3
`define SDB_BL_PAGE 3'h7
`define SDB_CL_MIN 2'h1
`define SDB_CL_RST 2'h3
// ------------------------------------------------------------
// Mask and write data latencies in clocks
// ------------------------------------------------------------
`define SDB_MASK_READ_FLOAT_LATENCY 2
`define SDB_MASK_WRITE_LATENCY 0
`define SDB_WRITE_DATA_DELAY 0
`endif

// ### hw/sdb_pkg.sv
// Types shared by the SDRAM device-side bank and read timing model
package sdb_pkg;
  // Command codes as {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    SDB_CMD_MRS = 3'h0,
    SDB_CMD_REF = 3'h1,
    SDB_CMD_PRE = 3'h2,
    SDB_CMD_ACT = 3'h3,
    SDB_CMD_WR = 3'h4,
    SDB_CMD_RD = 3'h5,
    SDB_CMD_BST = 3'h6,
    SDB_CMD_NOP = 3'h7
  } sdb_cmd_e;
  // Read engine, Gray along idle -> burst -> drain
  typedef enum logic [1:0] {
    SDB_RD_IDLE = 2'h0,
    SDB_RD_BURST = 2'h1,
    SDB_RD_DRAIN = 2'h3
  } sdb_rd_e;
endpackage

// ### hw/sdb_fifo.sv
// Parameterised valid/ready FIFO for read data words
`timescale 1ns/10ps
module sdb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  // ------------------------------------------------------------
  // Handshakes
  // ------------------------------------------------------------
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Storage has no reset, only pointers and occupancy do
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  // Pointers and occupancy
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ### hw/sdb_device.sv
// SDRAM device-side bank activation, read burst and data mask behaviour
// What this block does
// - Reads and writes to a bank not opened by activate raise cmd_error but are still served.
// - First word CAS latency after read, then one per edge; float after burst.
// - Read carries column, bank and auto-precharge; auto-precharge closes row.
// - Write truncating a read floats data pins once registered.
// - Mask disables read drivers two clocks after it is sampled.
// - Mask blocks write data in the clock it is sampled.
// - First write word is registered with the write command.
// - After precharge, CAS latency minus one words still come, then float.
// - Precharge address bit ten picks all banks, else bank bits pick one.
`timescale 1ns/10ps
`include "sdb_cfg.svh"
module sdb_device
  import sdb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [`SDB_BA_W-1:0] ba,
  input wire logic [`SDB_ROW_W-1:0] addr,
  input wire logic dqm,
  input wire logic [`SDB_DQ_W-1:0] dq_in,
  output logic [`SDB_DQ_W-1:0] dq_out,
  output logic dq_oe,
  output logic [`SDB_DQ_W-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [`SDB_BANKS-1:0] bank_open,
  output logic cmd_error
);
  localparam int CLW = 2;
  localparam int PIPE = 4;
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [`SDB_BANKS-1:0] open;
    logic [`SDB_BANKS-1:0][`SDB_ROW_W-1:0] row;
    sdb_rd_e rd_st;
    logic [`SDB_BA_W-1:0] rd_bank;
    logic [`SDB_COL_W-1:0] col;
    logic [`SDB_COL_W-1:0] left;
    logic rd_ap;
    logic [CLW-1:0] cl;
    logic [2:0] bl;
    logic [PIPE-1:0] vpipe;
    logic [PIPE-1:0][`SDB_MEM_AW-1:0] apipe;
    logic [1:0] mpipe;
    logic wr_act;
    logic [`SDB_BA_W-1:0] wr_bank;
    logic [`SDB_COL_W-1:0] wr_col;
    logic [`SDB_COL_W-1:0] wr_left;
    logic wr_ap;
    logic [`SDB_DQ_W-1:0] dq_out;
    logic dq_oe;
    logic err;
    logic acc;
  } sdb_state_s;
  sdb_state_s s_r;
  sdb_state_s s_nxt;
  logic [`SDB_DQ_W-1:0] mem_r [`SDB_MEM_WORDS];
  logic mem_we;
  logic [`SDB_MEM_AW-1:0] mem_wa;
  logic fifo_in_ready;
  logic [`SDB_DQ_W-1:0] rd_word;
  sdb_cmd_e cmd;
  // Burst length in words minus one, full page gives column span
  function automatic logic [`SDB_COL_W-1:0] burst_last(input logic [2:0] code);
    case (code)
      `SDB_BL_1: burst_last = `SDB_COL_W'(0);
      `SDB_BL_2: burst_last = `SDB_COL_W'(1);
      `SDB_BL_4: burst_last = `SDB_COL_W'(3);
      `SDB_BL_8: burst_last = `SDB_COL_W'(7);
      default: burst_last = '1;
    endcase
  endfunction
  // Storage word index from bank, row and column; a small window of the array
  function automatic logic [`SDB_MEM_AW-1:0] word_idx(input logic [`SDB_BA_W-1:0] b,
      input logic [`SDB_ROW_W-1:0] r, input logic [`SDB_COL_W-1:0] c);
    word_idx = `SDB_MEM_AW'({b, r[0], c[4:0]});
  endfunction
  // Wrap within the burst block; a full page wraps at the page end
  function automatic logic [`SDB_COL_W-1:0] next_col(input logic [`SDB_COL_W-1:0] c,
      input logic [2:0] code);
    logic [`SDB_COL_W-1:0] m;
    m = burst_last(code);
    next_col = (c & ~m) | ((c + `SDB_COL_W'(1)) & m);
  endfunction
  assign cmd = cs_n ? SDB_CMD_NOP : sdb_cmd_e'({ras_n, cas_n, we_n});
  // ------------------------------------------------------------
  // Command decode and burst engines
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Sticky access fault; a dropped word only shows for one cycle
    s_nxt.err = s_r.acc;
    mem_we = 1'b0;
    mem_wa = word_idx(s_r.wr_bank, s_r.row[s_r.wr_bank], s_r.wr_col);
    // Mask history feeds the two-clock read float
    s_nxt.mpipe = {s_r.mpipe[0], dqm};
    // Launch the word of the current read beat into the latency pipe
    s_nxt.vpipe = {s_r.vpipe[PIPE-2:0], 1'b0};
    s_nxt.apipe = {s_r.apipe[PIPE-2:0], word_idx(s_r.rd_bank, s_r.row[s_r.rd_bank], s_r.col)};
    if (s_r.rd_st == SDB_RD_BURST) begin
      s_nxt.vpipe[0] = 1'b1;
      s_nxt.col = next_col(s_r.col, s_r.bl);
      s_nxt.left = s_r.left - `SDB_COL_W'(1);
      if (s_r.left == '0 && s_r.bl != `SDB_BL_PAGE) begin
        s_nxt.rd_st = SDB_RD_DRAIN;
      end
    end
    if (s_r.rd_st == SDB_RD_DRAIN && s_r.vpipe == '0) begin
      s_nxt.rd_st = SDB_RD_IDLE;
      if (s_r.rd_ap) begin
        s_nxt.open[s_r.rd_bank] = 1'b0;
      end
    end
    // Write beats: mask blocks the word in its own clock
    if (s_r.wr_act) begin
      mem_we = !dqm;
      s_nxt.wr_col = next_col(s_r.wr_col, s_r.bl);
      s_nxt.wr_left = s_r.wr_left - `SDB_COL_W'(1);
      if (s_r.wr_left == '0 && s_r.bl != `SDB_BL_PAGE) begin
        s_nxt.wr_act = 1'b0;
        if (s_r.wr_ap) begin
          s_nxt.open[s_r.wr_bank] = 1'b0;
        end
      end
    end
    case (cmd)
      SDB_CMD_ACT: begin
        if (s_r.open[ba]) begin
          s_nxt.err = 1'b1;
        end
        s_nxt.open[ba] = 1'b1;
        s_nxt.row[ba] = addr;
      end
      SDB_CMD_RD: begin
        if (!s_r.open[ba]) begin
          s_nxt.err = 1'b1;
        end
        s_nxt.rd_st = SDB_RD_IDLE;
        s_nxt.wr_act = 1'b0;
        s_nxt.rd_bank = ba;
        s_nxt.rd_ap = addr[`SDB_AP_BIT];
        // A new read truncates the old one; its words follow back to back
        s_nxt.vpipe[0] = 1'b1;
        s_nxt.apipe[0] = word_idx(ba, s_r.row[ba], addr[`SDB_COL_W-1:0]);
        s_nxt.col = next_col(addr[`SDB_COL_W-1:0], s_r.bl);
        s_nxt.left = burst_last(s_r.bl);
        if (burst_last(s_r.bl) != '0) begin
          s_nxt.left = burst_last(s_r.bl) - `SDB_COL_W'(1);
          s_nxt.rd_st = SDB_RD_BURST;
        end else begin
          s_nxt.rd_st = SDB_RD_DRAIN;
        end
      end
      SDB_CMD_WR: begin
        if (!s_r.open[ba]) begin
          s_nxt.err = 1'b1;
        end
        // Write truncates any read; pending words are dropped at once
        s_nxt.rd_st = SDB_RD_IDLE;
        s_nxt.vpipe = '0;
        s_nxt.wr_bank = ba;
        s_nxt.wr_ap = addr[`SDB_AP_BIT];
        s_nxt.wr_col = next_col(addr[`SDB_COL_W-1:0], s_r.bl);
        s_nxt.wr_left = burst_last(s_r.bl) - `SDB_COL_W'(1);
        s_nxt.wr_act = (burst_last(s_r.bl) != '0);
        mem_we = !dqm;
        mem_wa = word_idx(ba, s_r.row[ba], addr[`SDB_COL_W-1:0]);
      end
      SDB_CMD_BST: begin
        // Words already launched still emerge, CAS latency minus one of them
        s_nxt.rd_st = (s_r.rd_st == SDB_RD_IDLE) ? SDB_RD_IDLE : SDB_RD_DRAIN;
        // The beat of this very edge is not launched, so the last word is CL-1 away
        s_nxt.vpipe[0] = 1'b0;
        s_nxt.rd_ap = 1'b0;
        s_nxt.wr_act = 1'b0;
      end
      SDB_CMD_PRE: begin
        if (addr[`SDB_AP_BIT]) begin
          s_nxt.open = '0;
        end else begin
          s_nxt.open[ba] = 1'b0;
        end
        if (addr[`SDB_AP_BIT] || ba == s_r.rd_bank) begin
          if (s_r.rd_st != SDB_RD_IDLE) begin
            s_nxt.rd_st = SDB_RD_DRAIN;
            s_nxt.vpipe[0] = 1'b0;
          end
          s_nxt.rd_ap = 1'b0;
        end
        if (addr[`SDB_AP_BIT] || ba == s_r.wr_bank) begin
          s_nxt.wr_act = 1'b0;
        end
      end
      SDB_CMD_MRS: begin
        s_nxt.bl = addr[2:0];
        s_nxt.cl = (addr[5:4] < `SDB_CL_MIN) ? `SDB_CL_MIN : addr[5:4];
      end
      default: begin
      end
    endcase
    // Output stage: word emerges CAS latency clocks after its launch
    s_nxt.dq_oe = 1'b0;
    s_nxt.dq_out = s_r.dq_out;
    if (s_r.vpipe[s_r.cl - CLW'(1)] && !s_r.mpipe[`SDB_MASK_READ_FLOAT_LATENCY-1]) begin
      s_nxt.dq_oe = (cmd != SDB_CMD_WR);
      s_nxt.dq_out = mem_r[s_r.apipe[s_r.cl - CLW'(1)]];
    end
    // Error output is a flop: sticky fault or a word lost at the full FIFO
    s_nxt.acc = s_nxt.err;
    s_nxt.err = s_nxt.err | (s_r.dq_oe & ~fifo_in_ready);
    if (cmd == SDB_CMD_WR) begin
      s_nxt.vpipe = '0;
    end
  end
  // ------------------------------------------------------------
  // Registers and storage
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.rd_st <= SDB_RD_IDLE;
      s_r.cl <= `SDB_CL_RST;
      s_r.bl <= `SDB_BL_4;
    end else begin
      s_r <= s_nxt;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem_r[mem_wa] <= dq_in;
    end
  end
  // Copy of every driven read word; words are lost only when the sink stalls long
  assign rd_word = s_r.dq_out;
  sdb_fifo #(
    .WIDTH(`SDB_DQ_W),
    .DEPTH(`SDB_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .in_valid(s_r.dq_oe),
    .in_ready(fifo_in_ready),
    .in_data(rd_word),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );
  assign dq_out = s_r.dq_out;
  assign dq_oe = s_r.dq_oe;
  assign bank_open = s_r.open;
  assign cmd_error = s_r.err;
endmodule

// ### dv/sdb_ctrl_model.sv
// Controller model issuing commands, mask and write data
`timescale 1ns/10ps
module sdb_ctrl_model
  import sdb_pkg::*;
#(
  parameter int CLK_NS = 40
) (
  input wire logic ref_clk,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] ba,
  output logic [12:0] addr,
  output logic dqm,
  output logic [15:0] dq_in
);
  // ----
  // Gaps in clocks, rounded up from nanoseconds
  // ----
  localparam int RC_CK = (60 + CLK_NS - 1) / CLK_NS;
  localparam int RP_CK = (18 + CLK_NS - 1) / CLK_NS;
  // No mode load, clock-enable change, self refresh or power-up refresh is issued
  // Idle pins at time zero so reset sees no command
  initial begin
    {cs_n, ras_n, cas_n, we_n, dqm} = 5'h1e;
    ba = 2'h0;
    addr = 13'h0;
    dq_in = 16'h0;
  end
  // One command per edge, pins change just after the edge
  task automatic issue(input sdb_cmd_e c, input logic [1:0] b, input logic [12:0] a,
                       input logic m, input logic [15:0] d);
    cs_n = (c == SDB_CMD_NOP);
    {ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
    dqm = m;
    dq_in = d;
    @(posedge ref_clk);
    #1;
  endtask
  // Released lines show the inverse of their last value
  task automatic nop(input int n, input logic m = 1'b0);
    repeat (n) issue(SDB_CMD_NOP, ~ba, ~addr, m, ~dq_in);
  endtask
  // Waiting a whole row cycle also covers the shorter gaps, at some cost in speed
  // Scenarios track the open rows themselves, at most two banks at a time
  task automatic act(input logic [1:0] b, input logic [12:0] r);
    issue(SDB_CMD_ACT, b, r, 1'b0, ~dq_in);
    nop(RC_CK - 1);
  endtask
  task automatic pre(input logic [1:0] b, input logic all);
    issue(SDB_CMD_PRE, b, {2'h0, all, 10'h0}, 1'b0, ~dq_in);
    nop(RP_CK - 1);
  endtask
  task automatic rd(input logic [1:0] b, input logic [9:0] c, input logic ap = 1'b0);
    issue(SDB_CMD_RD, b, {2'h0, ap, c}, 1'b0, ~dq_in);
  endtask
  task automatic bst();
    issue(SDB_CMD_BST, ~ba, ~addr, 1'b0, ~dq_in);
  endtask
  // Four-word write burst, mask bit i blanks word i
  task automatic wr4(input logic [1:0] b, input logic [9:0] c, input logic [15:0] d,
                     input logic [3:0] mk);
    issue(SDB_CMD_WR, b, {3'h0, c}, mk[0], d);
    // Next column command may follow the last word at once; precharge comes much later
    for (int i = 1; i < 4; i++) issue(SDB_CMD_NOP, ~ba, ~addr, mk[i], d + 16'(i));
  endtask
endmodule

// ### dv/sdb_device_monitor.sv
// Property checker for device read, mask and bank timing
`timescale 1ns/10ps
module sdb_device_monitor (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [12:0] addr,
  input wire logic dqm,
  input wire logic dq_oe,
  input wire logic [3:0] bank_open,
  input wire logic cmd_error
);
  // ----
  // Decoded commands, a deselected device sees none
  // ----
  wire logic act_c = !cs_n && !ras_n && cas_n && we_n;
  wire logic rd_c = !cs_n && ras_n && !cas_n && we_n;
  wire logic wr_c = !cs_n && ras_n && !cas_n && !we_n;
  wire logic pre_c = !cs_n && !ras_n && cas_n && !we_n;
  wire logic bst_c = !cs_n && ras_n && cas_n && !we_n;
  wire logic nop_c = cs_n || (ras_n && cas_n && we_n);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_read_first_word:
    assert property ((rd_c && bank_open[ba]) ##1 (nop_c && !dqm) ##1 nop_c |-> ##2 dq_oe)
      else $error("first read word missing");
  a_burst_then_float:
    assert property ((rd_c && bank_open[ba]) ##1 (nop_c && !dqm) [*6] |-> ##1 dq_oe ##1 !dq_oe)
      else $error("burst length wrong");
  a_mask_read_float:
    assert property (dqm |-> ##3 !dq_oe) else $error("mask did not float pins");
  a_stop_floats:
    assert property (bst_c ##1 nop_c [*3] |=> !dq_oe) else $error("stop did not float pins");
  a_pre_cuts_read:
    assert property ((rd_c && bank_open[ba] && !dqm) ##1 (pre_c && ba == $past(ba) && !dqm)
      ##1 (nop_c && !dqm) ##1 nop_c |-> ##1 dq_oe ##1 !dq_oe) else $error("precharge cut wrong");
  a_write_floats:
    assert property (wr_c |=> !dq_oe [*3]) else $error("write did not float pins");
  a_act_opens:
    assert property (act_c |=> bank_open[$past(ba)]) else $error("activate did not open bank");
  a_pre_closes:
    assert property (pre_c |=> (bank_open & ($past(addr[10]) ? 4'hf : 4'h1 << $past(ba))) == 4'h0)
      else $error("precharge left bank open");
  a_closed_access:
    assert property ((rd_c || wr_c) && !bank_open[ba] |=> cmd_error) else $error("no error flag");
  // Main scenarios reached
  c_read_word: cover property (rd_c ##3 dq_oe);
  c_mask_float: cover property (dqm ##3 !dq_oe);
  c_pre_all: cover property (pre_c && addr[10]);
endmodule
bind sdb_device sdb_device_monitor u_sdb_device_monitor (.ref_clk(ref_clk), .nrst(nrst),
  .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm),
  .dq_oe(dq_oe), .bank_open(bank_open), .cmd_error(cmd_error));

// ### dv/sdb_device_tb.sv
// Self-checking bench for the device read, mask and bank behaviour
`timescale 1ns/10ps
module sdb_device_tb;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic rd_ready = 1'b1;
  logic cs_n, ras_n, cas_n, we_n, dqm, dq_oe, rd_valid, cmd_error, err_seen;
  logic [1:0] ba;
  logic [12:0] addr;
  logic [15:0] dq_in, dq_out, rd_data;
  logic [3:0] bank_open;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  sdb_ctrl_model u_sdb_ctrl_model (.ref_clk(ref_clk), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in));
  sdb_device u_sdb_device (.ref_clk(ref_clk), .nrst(nrst), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .bank_open(bank_open), .cmd_error(cmd_error));
  // ----
  // Clock, hang guard and helpers
  // ----
  always #20 ref_clk = ~ref_clk;
  // Ceiling is some fourteen times the expected run; dropped words are latched
  always @(posedge ref_clk) begin
    cyc++;
    if (cmd_error === 1'b1) err_seen = 1'b1;
    if (cyc == 2000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic nop(input int n, input logic m = 1'b0);
    u_sdb_ctrl_model.nop(n, m);
  endtask
  // Four words one per edge after the lead cycles, then the pins float
  task automatic burst(input logic [63:0] e, input int lead);
    nop(lead);
    for (int i = 3; i >= 0; i--) begin
      nop(1);
      chk({dq_oe, dq_out}, {1'b1, e[i*16 +: 16]});
    end
    nop(1);
    chk(dq_oe, 1'b0);
  endtask
  task automatic do_reset();
    nrst = 1'b0;
    nop(5);
    nrst = 1'b1;
    chk({bank_open, dq_oe, cmd_error, rd_valid}, 7'h0);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_write_read();
    u_sdb_ctrl_model.act(2'h1, 13'h5);
    chk(bank_open, 4'h2);
    u_sdb_ctrl_model.wr4(2'h1, 10'h0, 16'h1000, 4'h0);
    u_sdb_ctrl_model.wr4(2'h1, 10'h4, 16'h2000, 4'h0);
    u_sdb_ctrl_model.wr4(2'h1, 10'h0, 16'h3000, 4'h2);
    u_sdb_ctrl_model.rd(2'h1, 10'h0);
    burst(64'h3000_1001_3002_3003, 2);
  endtask
  task automatic t_gapless();
    u_sdb_ctrl_model.rd(2'h1, 10'h0);
    u_sdb_ctrl_model.rd(2'h1, 10'h4);
    nop(2);
    chk({dq_oe, dq_out}, {1'b1, 16'h3000});
    burst(64'h2000_2001_2002_2003, 0);
  endtask
  task automatic t_pre_stop();
    u_sdb_ctrl_model.rd(2'h1, 10'h0);
    u_sdb_ctrl_model.pre(2'h1, 1'b0);
    nop(2);
    chk({dq_oe, dq_out}, {1'b1, 16'h3000});
    nop(1);
    chk({dq_oe, bank_open}, 5'h0);
    u_sdb_ctrl_model.act(2'h1, 13'h5);
    u_sdb_ctrl_model.rd(2'h1, 10'h0);
    u_sdb_ctrl_model.bst();
    nop(2);
    chk({dq_oe, dq_out}, {1'b1, 16'h3000});
    nop(1);
    chk(dq_oe, 1'b0);
    u_sdb_ctrl_model.rd(2'h1, 10'h0, 1'b1);
    burst(64'h3000_1001_3002_3003, 2);
    nop(2);
    chk(bank_open, 4'h0);
    u_sdb_ctrl_model.act(2'h0, 13'h1);
    u_sdb_ctrl_model.act(2'h2, 13'h3);
    chk(bank_open, 4'h5);
    u_sdb_ctrl_model.pre(2'h1, 1'b1);
    chk(bank_open, 4'h0);
  endtask
  task automatic t_mask_write();
    u_sdb_ctrl_model.act(2'h1, 13'h5);
    u_sdb_ctrl_model.rd(2'h1, 10'h0);
    nop(2);
    nop(1, 1'b1);
    chk({dq_oe, dq_out}, {1'b1, 16'h3000});
    nop(1);
    chk({dq_oe, dq_out}, {1'b1, 16'h1001});
    nop(1);
    chk(dq_oe, 1'b0);
    nop(1);
    chk({dq_oe, dq_out}, {1'b1, 16'h3003});
    u_sdb_ctrl_model.rd(2'h1, 10'h4);
    nop(2, 1'b1);
    u_sdb_ctrl_model.wr4(2'h1, 10'h0, 16'h4000, 4'h0);
    chk(dq_oe, 1'b0);
    u_sdb_ctrl_model.rd(2'h1, 10'h0);
    burst(64'h4000_4001_4002_4003, 2);
  endtask
  // Reader stalls while twenty words arrive, then drains sixteen
  task automatic t_fifo();
    nop(4);
    chk(rd_valid, 1'b0);
    rd_ready = 1'b0;
    err_seen = 1'b0;
    repeat (5) begin
      u_sdb_ctrl_model.rd(2'h1, 10'h0);
      nop(3);
    end
    nop(6);
    chk(err_seen, 1'b1);
    rd_ready = 1'b1;
    for (int i = 0; i < 16; i++) begin
      chk({rd_valid, rd_data}, {1'b1, 16'h4000 + 16'(i % 4)});
      nop(1);
    end
    chk(rd_valid, 1'b0);
  endtask
  task automatic t_errors();
    u_sdb_ctrl_model.rd(2'h3, 10'h0);
    chk(cmd_error, 1'b1);
    do_reset();
    u_sdb_ctrl_model.act(2'h3, 13'h0);
    chk({bank_open, cmd_error}, 5'h10);
    u_sdb_ctrl_model.act(2'h3, 13'h0);
    chk(cmd_error, 1'b1);
  endtask
  // Main sequence
  initial begin
    do_reset();
    t_write_read();
    t_gapless();
    t_pre_stop();
    t_mask_write();
    t_fifo();
    t_errors();
    final_report();
  end
endmodule
